// ==== verilog/pic_regs.vh ====
// Constants for the cascaded legacy interrupt controller.
// Assumes AXI4-Lite byte addresses equal four times the register index.
// Contract
// - Master core serves lines 7..0, slave 15..8, slave cascaded on line 2.
// - Line 0 comes from interval timer counter 0 as system timer.
// - Line 13 comes internally from the floating-point error signal.
// - Only lines 15, 14, 12..3 and 1 are taken from external sources.
// - Reset defaults: x86 vectors, all edge, normal EOI, cascade mode.
// - Edge or level sensing is selectable per request line, except lines 0, 1, 2, 8 and 13.
// - Chip-select config bit 4 picks mouse source for line 12.
// - Four PCI lines and the board line route to eleven legacy lines.
// - Board-zero routing bit 5 turns the board pin into line 0 output.
// - Master ports at index 20h/21h, slave at A0h/A1h.
// - Base-port write with data bit 4 set starts initialization.
// - Mask word bit set to 1 blocks that request line.
// - Second operation word does end-of-interrupt and rotation.
// - Third operation word picks readback, special mask, polling.
// - Operation words are accepted any time after initialization.
// - Edge-selected lines request only on a rising transition.
// - Level-selected lines request while high, no edge detection.
// - Lines 0, 1, 2, 8 and 13 stay edge triggered always.
// - Request gone before acknowledge gives line 7 vector, no in-service.
`ifndef PIC_REGS_VH
`define PIC_REGS_VH

// Register indices; byte address is index times four
`define IDX_MASTER_CMD   10'h020
`define IDX_MASTER_DATA  10'h021
`define IDX_SLAVE_CMD    10'h0a0
`define IDX_SLAVE_DATA   10'h0a1
`define IDX_ELS_LOW      10'h030
`define IDX_ELS_HIGH     10'h031
`define IDX_PCI_ROUTE0   10'h038
`define IDX_BOARD_ROUTE  10'h03c
`define IDX_XBUS_CFG     10'h03d
`define IDX_ACK          10'h03e

// Field positions
`define ROUTE_DISABLE    7
`define ROUTE_IRQ0_OUT   5
`define XBUS_MOUSE_BIT   4
`define AEOI_BIT         1

// Reset values
`define ROUTE_RESET      8'h80
`define XBUS_RESET       8'h00
`define MODE_RESET       8'h01
`define MASTER_CAS_RESET 8'h04
`define SLAVE_CAS_RESET  8'h02
`define SYNC_IDLE        22'h2f0000

// Line masks
`define ELS_WRITABLE     16'hdef8
`define ROUTABLE_LINES   16'hdef8
`define EXTERNAL_LINES   16'hdffa
`define MOUSE_LINE_MASK  16'h1000
`define SPURIOUS_LINE    3'h7
`define CASCADE_LINE     3'h2

// Second operation word codes, bits 7:5
`define EOI_NONSPEC      3'h1
`define EOI_SPEC         3'h3
`define ROT_NONSPEC      3'h5
`define ROT_SPEC         3'h7
`define SET_PRIORITY     3'h6
`define ROT_AEOI_SET     3'h4
`define ROT_AEOI_CLR     3'h0

// Bus responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// ==== verilog/priority_core.v ====
// One eight-line priority core with init and operation word decode.
// Assumes request lines are already synchronised to aclk.
`timescale 1ns/1ps
`include "pic_regs.vh"
module priority_core #(
  parameter [7:0] CAS_INIT = `MASTER_CAS_RESET
) (
  // Clock and reset
  input  wire       aclk,
  input  wire       aresetn,
  // Command port
  input  wire       wr_en,
  input  wire       rd_en,
  input  wire       port_sel,
  input  wire [7:0] wr_data,
  output wire [7:0] rd_data,
  // Requests
  input  wire [7:0] req_lines,
  input  wire [7:0] level_sel,
  // Acknowledge
  input  wire       ack_en,
  output wire       int_out,
  output wire [2:0] ack_line,
  output wire [7:0] vector,
  output wire [7:0] cascade_map
);

  localparam ST_UNINIT = 3'd0;
  localparam ST_W2     = 3'd1;
  localparam ST_W3     = 3'd2;
  localparam ST_W4     = 3'd3;
  localparam ST_READY  = 3'd4;

  reg [2:0] state_q;
  reg [7:0] prev_q;
  reg [7:0] irr_q;
  reg [7:0] isr_q;
  reg [7:0] imr_q;
  reg [7:0] base_q;
  reg [7:0] cas_q;
  reg [7:0] mode_q;
  reg [2:0] low_q;
  reg       rot_aeoi_q;
  reg       smm_q;
  reg       poll_q;
  reg       ris_q;
  reg [7:0] isr_clr;
  reg [2:0] low_d;

  // Scan from just above the lowest-priority line; returns {found, line}
  function [3:0] pick;
    input [7:0] pend;
    input [7:0] svc;
    input [2:0] low;
    input       special_mask_mode;
    integer     i;
    reg [2:0]   p;
    reg         stop;
    begin
      pick = 4'h0;
      stop = 1'b0;
      for (i = 1; i <= 8; i = i + 1)
      begin
        p = low + i[2:0];
        if (!stop)
        begin
          if (svc[p] && !special_mask_mode)
            stop = 1'b1;
          else if (pend[p])
          begin
            pick = {1'b1, p};
            stop = 1'b1;
          end
        end
      end
    end
  endfunction

  wire       ready = (state_q == ST_READY);
  wire [7:0] pend = irr_q & ~imr_q & (smm_q ? ~isr_q : 8'hff);
  wire [3:0] best = pick(pend, isr_q, low_q, smm_q);
  wire [3:0] top_svc = pick(isr_q, 8'h00, low_q, 1'b0);
  wire       poll_rd = rd_en & ~port_sel & poll_q;
  wire       take = (ack_en | poll_rd) & ready & best[3];
  wire [7:0] take_hot = take ? (8'h01 << best[2:0]) : 8'h00;
  wire       cmd_wr = wr_en & ~port_sel;
  wire       init_word_one = cmd_wr & wr_data[4];
  wire       readback_poll_operation_word = cmd_wr & ~wr_data[4] & wr_data[3] & ready;
  wire       eoi_rotate_operation_word = cmd_wr & ~wr_data[4] & ~wr_data[3] & ready;
  // Edge: rise sets, fall or ack clears
  wire [7:0] irr_d = req_lines & (level_sel | ((irr_q | ~prev_q) & ~take_hot));

  assign int_out = ready & best[3];
  // No pending line gives line 7
  assign ack_line = best[3] ? best[2:0] : `SPURIOUS_LINE;
  assign vector = {base_q[7:3], ack_line};
  assign cascade_map = cas_q;
  assign rd_data = port_sel ? imr_q :
                   poll_q ? {best[3], 4'h0, best[2:0]} :
                   ris_q ? isr_q : irr_q;

  always @*
  begin
    isr_clr = 8'h00;
    low_d = low_q;
    if (eoi_rotate_operation_word)
    begin
      case (wr_data[7:5])
        `EOI_NONSPEC:
          isr_clr = top_svc[3] ? (8'h01 << top_svc[2:0]) : 8'h00;
        `ROT_NONSPEC:
        begin
          isr_clr = top_svc[3] ? (8'h01 << top_svc[2:0]) : 8'h00;
          if (top_svc[3])
            low_d = top_svc[2:0];
        end
        `EOI_SPEC:
          isr_clr = 8'h01 << wr_data[2:0];
        `ROT_SPEC:
        begin
          isr_clr = 8'h01 << wr_data[2:0];
          low_d = wr_data[2:0];
        end
        `SET_PRIORITY:
          low_d = wr_data[2:0];
        default:
          isr_clr = 8'h00;
      endcase
    end
    if (take && mode_q[`AEOI_BIT] && rot_aeoi_q)
      low_d = best[2:0];
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q    <= ST_UNINIT;
      prev_q     <= 8'h00;
      irr_q      <= 8'h00;
      isr_q      <= 8'h00;
      imr_q      <= 8'h00;
      base_q     <= 8'h00;
      cas_q      <= CAS_INIT;
      mode_q     <= `MODE_RESET;
      low_q      <= 3'h7;
      rot_aeoi_q <= 1'b0;
      smm_q      <= 1'b0;
      poll_q     <= 1'b0;
      ris_q      <= 1'b0;
    end
    else
    begin
      prev_q <= req_lines;
      irr_q  <= irr_d;
      // Auto-EOI never marks in-service
      isr_q  <= init_word_one ? 8'h00 :
                (isr_q & ~isr_clr) | (mode_q[`AEOI_BIT] ? 8'h00 : take_hot);
      low_q  <= init_word_one ? 3'h7 : low_d;
      if (init_word_one)
      begin
        imr_q   <= 8'h00;
        smm_q   <= 1'b0;
        ris_q   <= 1'b0;
        poll_q  <= 1'b0;
        state_q <= ST_W2;
      end
      else
      begin
        if (wr_en && port_sel)
        begin
          case (state_q)
            ST_W2:
            begin
              base_q  <= wr_data;
              state_q <= ST_W3;
            end
            ST_W3:
            begin
              cas_q   <= wr_data;
              state_q <= ST_W4;
            end
            ST_W4:
            begin
              mode_q  <= wr_data;
              state_q <= ST_READY;
            end
            ST_READY:
              imr_q <= wr_data;
            default:
              state_q <= state_q;
          endcase
        end
        if (readback_poll_operation_word)
        begin
          if (wr_data[6])
            smm_q <= wr_data[5];
          if (wr_data[1])
            ris_q <= wr_data[0];
          poll_q <= wr_data[2];
        end
        else if (poll_rd)
          poll_q <= 1'b0;
        if (eoi_rotate_operation_word && wr_data[7:5] == `ROT_AEOI_SET)
          rot_aeoi_q <= 1'b1;
        else if (eoi_rotate_operation_word && wr_data[7:5] == `ROT_AEOI_CLR)
          rot_aeoi_q <= 1'b0;
      end
    end
  end

endmodule

// ==== verilog/cascaded_pic.v ====
// Two cascaded priority cores, line steering and an AXI4-Lite slave.
// Assumes pins are asynchronous; timer and mouse sources run on aclk.
`timescale 1ns/1ps
`include "pic_regs.vh"
module cascaded_pic (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // Internal sources
  input  wire        timer0_out,
  input  wire        mouse_request_source,
  // Pins
  input  wire        fpu_error_signal_n,
  input  wire [15:0] isa_irq_pins,
  input  wire [3:0]  pci_shared_request_lines_n,
  input  wire        board_request_zero_i,
  output wire        board_request_zero_o,
  output wire        board_request_zero_oe,
  // Processor
  output wire        intr
);

  // Bus state
  reg         bvalid_q;
  reg  [1:0]  bresp_q;
  reg         rvalid_q;
  reg  [1:0]  rresp_q;
  reg  [31:0] rdata_q;
  reg  [31:0] rdata_d;
  reg         rhit_d;
  reg         whit_d;

  // Own registers
  reg  [15:0] els_q;
  reg  [31:0] pci_route_q;
  reg  [7:0]  board_route_q;
  reg  [7:0]  xbus_cfg_q;
  reg         intr_q;
  reg         irq0_out_q;
  reg         board_oe_q;

  // Pin synchronisers: first stage read only by second
  reg  [21:0] sync1_q;
  reg  [21:0] sync2_q;

  wire [15:0] ext_s   = sync2_q[15:0];
  wire [3:0]  pci_n_s = sync2_q[19:16];
  wire        board_s = sync2_q[20];
  wire        fpu_n_s = sync2_q[21];

  // One-hot legacy line for a routing byte; disabled or illegal gives none
  function [15:0] route_hot;
    input [7:0] ctl;
    begin
      if (ctl[`ROUTE_DISABLE])
        route_hot = 16'h0000;
      else
        route_hot = (16'h0001 << ctl[3:0]) & `ROUTABLE_LINES;
    end
  endfunction

  // Handshakes
  // Write takes both channels at once; an unanswered response holds it off
  wire        w_hs  = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
  // Read waits while earlier data still stands for rready
  wire        ar_hs = s_axi_arvalid & ~rvalid_q;
  wire [9:0]  widx  = s_axi_awaddr[11:2];
  wire [9:0]  ridx  = s_axi_araddr[11:2];
  wire        wen   = w_hs & s_axi_wstrb[0];
  wire [7:0]  wbyte = s_axi_wdata[7:0];

  wire m_wr = wen & (widx == `IDX_MASTER_CMD || widx == `IDX_MASTER_DATA);
  wire s_wr = wen & (widx == `IDX_SLAVE_CMD || widx == `IDX_SLAVE_DATA);
  wire m_rd = ar_hs & (ridx == `IDX_MASTER_CMD || ridx == `IDX_MASTER_DATA);
  wire s_rd = ar_hs & (ridx == `IDX_SLAVE_CMD || ridx == `IDX_SLAVE_DATA);
  wire ack_rd = ar_hs & (ridx == `IDX_ACK);

  // Line assembly
  wire        mouse_sel = xbus_cfg_q[`XBUS_MOUSE_BIT];
  wire [15:0] ext_used = ext_s & `EXTERNAL_LINES & ~(mouse_sel ? `MOUSE_LINE_MASK : 16'h0000);
  wire [15:0] internal_lines = {2'b00, ~fpu_n_s, mouse_sel & mouse_request_source,
                                11'h000, timer0_out};
  // No arbitration: shared lines routed to one input are simply ORed
  // Shared lines steered, active low
  wire [15:0] pci_hot = (~pci_n_s[0] ? route_hot(pci_route_q[7:0])   : 16'h0000) |
                        (~pci_n_s[1] ? route_hot(pci_route_q[15:8])  : 16'h0000) |
                        (~pci_n_s[2] ? route_hot(pci_route_q[23:16]) : 16'h0000) |
                        (~pci_n_s[3] ? route_hot(pci_route_q[31:24]) : 16'h0000);
  // Board line steered unless pin is output
  wire [15:0] board_hot = (board_s & ~board_oe_q) ? route_hot(board_route_q) : 16'h0000;
  wire [15:0] all_lines = ext_used | internal_lines | pci_hot | board_hot;
  wire [15:0] level_sel = els_q & `ELS_WRITABLE;

  // Core wiring
  wire [7:0] m_rdata;
  wire [7:0] s_rdata;
  wire       m_int;
  wire       s_int;
  wire [2:0] m_line;
  wire [7:0] m_vec;
  wire [7:0] s_vec;
  wire [7:0] m_cas;
  // Slave vector only if the master marks line 2 as cascade
  // Cascade hit hands vector to slave
  wire       cas_hit = m_int & (m_line == `CASCADE_LINE) & m_cas[`CASCADE_LINE];
  wire       s_ack   = ack_rd & cas_hit;

  // Master core, slave on line 2
  priority_core #(
    .CAS_INIT (`MASTER_CAS_RESET)
  ) master_priority_core (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .wr_en       (m_wr),
    .rd_en       (m_rd),
    .port_sel    (m_wr ? widx[0] : ridx[0]),
    .wr_data     (wbyte),
    .rd_data     (m_rdata),
    .req_lines   ({all_lines[7:3], s_int, all_lines[1:0]}),
    .level_sel   (level_sel[7:0]),
    .ack_en      (ack_rd),
    .int_out     (m_int),
    .ack_line    (m_line),
    .vector      (m_vec),
    .cascade_map (m_cas)
  );

  priority_core #(
    .CAS_INIT (`SLAVE_CAS_RESET)
  ) slave_priority_core (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .wr_en       (s_wr),
    .rd_en       (s_rd),
    .port_sel    (s_wr ? widx[0] : ridx[0]),
    .wr_data     (wbyte),
    .rd_data     (s_rdata),
    .req_lines   (all_lines[15:8]),
    .level_sel   (level_sel[15:8]),
    .ack_en      (s_ack),
    .int_out     (s_int),
    .ack_line    (),
    .vector      (s_vec),
    .cascade_map ()
  );

  // Write address decode
  always @*
  begin
    case (widx)
      `IDX_MASTER_CMD, `IDX_MASTER_DATA, `IDX_SLAVE_CMD, `IDX_SLAVE_DATA,
      `IDX_ELS_LOW, `IDX_ELS_HIGH, `IDX_BOARD_ROUTE, `IDX_XBUS_CFG:
        whit_d = 1'b1;
      default:
        whit_d = (widx[9:2] == `IDX_PCI_ROUTE0 >> 2);
    endcase
  end

  // Read mux
  always @*
  begin
    rdata_d = 32'h0000_0000;
    rhit_d  = 1'b1;
    case (ridx)
      `IDX_MASTER_CMD, `IDX_MASTER_DATA:
        rdata_d[7:0] = m_rdata;
      `IDX_SLAVE_CMD, `IDX_SLAVE_DATA:
        rdata_d[7:0] = s_rdata;
      `IDX_ELS_LOW:
        rdata_d[7:0] = level_sel[7:0];
      `IDX_ELS_HIGH:
        rdata_d[7:0] = level_sel[15:8];
      `IDX_BOARD_ROUTE:
        rdata_d[7:0] = board_route_q;
      `IDX_XBUS_CFG:
        rdata_d[7:0] = xbus_cfg_q;
      // Reading this index is the acknowledge cycle itself
      `IDX_ACK:
        rdata_d[7:0] = cas_hit ? s_vec : m_vec;
      default:
      begin
        // Four route bytes share one aligned group of indices
        if (ridx[9:2] == `IDX_PCI_ROUTE0 >> 2)
          rdata_d[7:0] = pci_route_q[ridx[1:0]*8 +: 8];
        else
          rhit_d = 1'b0;
      end
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // Idle pin levels, so no false request edge follows reset
      sync1_q       <= `SYNC_IDLE;
      sync2_q       <= `SYNC_IDLE;
      bvalid_q      <= 1'b0;
      bresp_q       <= `RESP_OKAY;
      rvalid_q      <= 1'b0;
      rresp_q       <= `RESP_OKAY;
      rdata_q       <= 32'h0000_0000;
      els_q         <= 16'h0000;
      pci_route_q   <= {4{`ROUTE_RESET}};
      board_route_q <= `ROUTE_RESET;
      xbus_cfg_q    <= `XBUS_RESET;
      intr_q        <= 1'b0;
      irq0_out_q    <= 1'b0;
      board_oe_q    <= 1'b0;
    end
    else
    begin
      sync1_q <= {fpu_error_signal_n, board_request_zero_i,
                  pci_shared_request_lines_n, isa_irq_pins};
      sync2_q <= sync1_q;
      // Registered so the processor never sees a decode glitch
      intr_q  <= m_int;
      // Line 0 out to external controller
      irq0_out_q <= all_lines[0];
      // Pin turns around one cycle after the route write lands
      board_oe_q <= board_route_q[`ROUTE_IRQ0_OUT];

      // Write channel
      if (w_hs)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= whit_d ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_q <= 1'b0;
      if (wen)
      begin
        case (widx)
          `IDX_ELS_LOW:
            els_q[7:0] <= wbyte;
          `IDX_ELS_HIGH:
            els_q[15:8] <= wbyte;
          `IDX_BOARD_ROUTE:
            board_route_q <= wbyte;
          `IDX_XBUS_CFG:
            xbus_cfg_q <= wbyte;
          default:
          begin
            if (widx[9:2] == `IDX_PCI_ROUTE0 >> 2)
              pci_route_q[widx[1:0]*8 +: 8] <= wbyte;
          end
        endcase
      end

      // Read channel
      if (ar_hs)
      begin
        rvalid_q <= 1'b1;
        rdata_q  <= rdata_d;
        rresp_q  <= rhit_d ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_rready)
        rvalid_q <= 1'b0;
    end
  end

  assign s_axi_awready         = w_hs;
  assign s_axi_wready          = w_hs;
  assign s_axi_bvalid          = bvalid_q;
  assign s_axi_bresp           = bresp_q;
  assign s_axi_arready         = ar_hs;
  assign s_axi_rvalid          = rvalid_q;
  assign s_axi_rdata           = rdata_q;
  assign s_axi_rresp           = rresp_q;
  assign intr                  = intr_q;
  assign board_request_zero_o  = irq0_out_q;
  assign board_request_zero_oe = board_oe_q;

endmodule

// ==== test/axil_host.sv ====
// Host model: AXI4-Lite master that issues the processor's port accesses.
// Assumes each task is entered just after a rising aclk edge.
`timescale 1ns/1ps
module axil_host (
  // Clock
  input  logic        aclk,
  // Write channels
  output logic [11:0] awaddr,
  output logic        awvalid,
  input  logic        awready,
  output logic [31:0] wdata,
  output logic [3:0]  wstrb,
  output logic        wvalid,
  input  logic        wready,
  input  logic [1:0]  bresp,
  input  logic        bvalid,
  output logic        bready,
  // Read channels
  output logic [11:0] araddr,
  output logic        arvalid,
  input  logic        arready,
  input  logic [31:0] rdata,
  input  logic [1:0]  rresp,
  input  logic        rvalid,
  output logic        rready
);
  initial
  begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    bit done;
    done = 0;
    awaddr  <= a;
    wdata   <= {24'h0, d};
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        r = bresp;
        bready <= 1'b0;
        done = 1;
      end
    end
    // Let an edge pass so a next call never redrives bready in one step
    @(posedge aclk);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    bit done;
    done = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid && rready)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1;
      end
    end
    // Let an edge pass so a next call never redrives rready in one step
    @(posedge aclk);
  endtask
endmodule

// ==== test/cascaded_pic_checker.sv ====
// Checker: bus handshakes and pin relations at the controller's ports.
// Assumes one clock, aclk, and synchronous active-low aresetn.
`timescale 1ns/1ps
module cascaded_pic_checker (
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Bus
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // Pins
  input wire        timer0_out,
  input wire        board_request_zero_o,
  input wire        board_request_zero_oe,
  input wire        intr
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_take;
    s_axi_awvalid && s_axi_wvalid && s_axi_awready && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Cores stay uninitialised for at least this long
  sequence s_no_intr;
    !intr [*8];
  endsequence

  property p_wr_answer;
    s_wr_take |=> s_axi_bvalid;
  endproperty
  property p_wr_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_wr_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_rd_answer;
    s_rd_take |=> s_axi_rvalid;
  endproperty
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_rd_byte;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  property p_oe_copy;
    board_request_zero_oe && $past(board_request_zero_oe)
      |-> board_request_zero_o == $past(timer0_out);
  endproperty
  property p_quiet;
    $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid ##0 s_no_intr;
  endproperty

  a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
  a_wr_hold: assert property (p_wr_hold) else $error("write response dropped");
  a_wr_refuse: assert property (p_wr_refuse) else $error("write taken early");
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  a_rd_hold: assert property (p_rd_hold) else $error("read data changed");
  a_rd_byte: assert property (p_rd_byte) else $error("upper read bits set");
  a_oe_copy: assert property (p_oe_copy) else $error("board pin not line 0");
  a_quiet: assert property (p_quiet) else $error("activity after reset");
endmodule

bind cascaded_pic cascaded_pic_checker chk_u (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .timer0_out, .board_request_zero_o,
  .board_request_zero_oe, .intr
);

// ==== test/cascaded_legacy_interrupt_controller_tb_top.sv ====
// Bench: host model drives the bus, the bench drives the request sources.
// Assumes the controller answers every bus request within a few cycles.
`timescale 1ns/1ps
module cascaded_legacy_interrupt_controller_tb_top;
  `define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
  logic        aclk, aresetn, timer0_out, mouse_src, fpu_n, board_i;
  logic [15:0] isa_pins;
  logic [3:0]  pci_n;
  wire  [11:0] awaddr, araddr;
  wire  [31:0] wdata, rdata;
  wire  [3:0]  wstrb;
  wire  [1:0]  bresp, rresp;
  wire         awvalid, awready, wvalid, wready, bvalid, bready;
  wire         arvalid, arready, rvalid, rready, board_o, board_oe, intr;
  int          error_cnt, checked, cyc;

  axil_host host_u (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  cascaded_pic dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .timer0_out(timer0_out), .mouse_request_source(mouse_src),
    .fpu_error_signal_n(fpu_n), .isa_irq_pins(isa_pins),
    .pci_shared_request_lines_n(pci_n), .board_request_zero_i(board_i),
    .board_request_zero_o(board_o), .board_request_zero_oe(board_oe), .intr(intr));

  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // Run should need a few hundred cycles
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      summarize;
    end
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic tend(input string nm);
    $display("test %s done", nm);
  endtask

  task automatic w(input logic [11:0] a, input logic [7:0] d);
    logic [1:0] rs;
    host_u.wr(a, d, rs);
    `CHK("bresp", 2'h0, rs)
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e, input string nm);
    logic [31:0] d;
    logic [1:0]  rs;
    host_u.rd(a, d, rs);
    `CHK(nm, {2'h0, 24'h0, e}, {rs, d})
  endtask

  task automatic init(input logic [11:0] base, input logic [7:0] vb, input logic [7:0] cas);
    w(base, 8'h11);
    w(base + 12'h4, vb);
    w(base + 12'h4, cas);
    w(base + 12'h4, 8'h01);
  endtask

  task automatic eoi2;
    w(12'h280, 8'h20);
    w(12'h080, 8'h20);
  endtask

  initial
  begin
    logic [31:0] d;
    logic [1:0]  rs;
    {aresetn, timer0_out, mouse_src, board_i, isa_pins} = '0;
    fpu_n = 1'b1;
    pci_n = 4'hf;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h0c0, 8'h00, "els_low");
    rd(12'h0e0, 8'h80, "pci_route");
    rd(12'h0f4, 8'h00, "xbus_cfg");
    host_u.rd(12'h100, d, rs);
    `CHK("unmapped_resp", 2'h2, rs)
    w(12'h0c0, 8'hff);
    rd(12'h0c0, 8'hf8, "els_low_fixed");
    w(12'h0c4, 8'hff);
    rd(12'h0c4, 8'hde, "els_high_fixed");
    w(12'h0c0, 8'h00);
    w(12'h0c4, 8'h00);
    timer0_out <= 1'b1;
    wt(8);
    `CHK("intr_uninit", 1'b0, intr)
    timer0_out <= 1'b0;
    init(12'h080, 8'h08, 8'h04);
    init(12'h280, 8'h70, 8'h02);
    rd(12'h084, 8'h00, "mask_init");
    tend("reset_init");
    timer0_out <= 1'b1;
    wt(8);
    `CHK("intr_timer", 1'b1, intr)
    rd(12'h0f8, 8'h08, "vec_timer");
    w(12'h080, 8'h0b);
    rd(12'h080, 8'h01, "isr_timer");
    w(12'h080, 8'h20);
    rd(12'h080, 8'h00, "isr_eoi");
    timer0_out <= 1'b0;
    w(12'h084, 8'h02);
    isa_pins[1] <= 1'b1;
    wt(8);
    `CHK("intr_masked", 1'b0, intr)
    w(12'h084, 8'h00);
    wt(4);
    rd(12'h0f8, 8'h09, "vec_line1");
    w(12'h080, 8'h61);
    rd(12'h080, 8'h00, "isr_spec_eoi");
    tend("ack_mask");
    isa_pins[3] <= 1'b1;
    wt(8);
    rd(12'h0f8, 8'h0b, "vec_edge");
    w(12'h080, 8'h20);
    wt(8);
    `CHK("intr_edge_held", 1'b0, intr)
    w(12'h0c0, 8'h08);
    wt(8);
    rd(12'h0f8, 8'h0b, "vec_level");
    w(12'h080, 8'h20);
    wt(8);
    `CHK("intr_level_held", 1'b1, intr)
    isa_pins[3] <= 1'b0;
    wt(8);
    `CHK("intr_level_gone", 1'b0, intr)
    w(12'h0c0, 8'h00);
    isa_pins[4] <= 1'b1;
    wt(8);
    isa_pins[4] <= 1'b0;
    wt(8);
    rd(12'h0f8, 8'h0f, "vec_spurious");
    rd(12'h080, 8'h00, "isr_spurious");
    tend("sense_spurious");
    fpu_n <= 1'b0;
    wt(8);
    rd(12'h0f8, 8'h75, "vec_fpu");
    eoi2;
    fpu_n <= 1'b1;
    w(12'h0e0, 8'h0a);
    pci_n[0] <= 1'b0;
    wt(8);
    rd(12'h0f8, 8'h72, "vec_pci");
    eoi2;
    pci_n[0] <= 1'b1;
    mouse_src <= 1'b1;
    wt(8);
    `CHK("intr_mouse_off", 1'b0, intr)
    w(12'h0f4, 8'h10);
    wt(8);
    rd(12'h0f8, 8'h74, "vec_mouse");
    eoi2;
    w(12'h080, 8'h0c);
    isa_pins[5] <= 1'b1;
    wt(8);
    rd(12'h080, 8'h85, "poll_read");
    w(12'h080, 8'h20);
    tend("cascade_poll");
    w(12'h080, 8'hc4);
    isa_pins[6:4] <= 3'h7;
    wt(8);
    rd(12'h0f8, 8'h0e, "vec_prio");
    tend("set_priority");
    w(12'h0f0, 8'ha0);
    timer0_out <= 1'b1;
    wt(3);
    `CHK("board_oe", 1'b1, board_oe)
    `CHK("board_o", 1'b1, board_o)
    aresetn <= 1'b0;
    wt(5);
    aresetn <= 1'b1;
    `CHK("oe_reset", 1'b0, board_oe)
    rd(12'h0f0, 8'h80, "board_route_reset");
    tend("board_reset");
    summarize;
  end
endmodule
